/* fetcp_fifo.sv */
`default_nettype none
module fetcp_fifo #(
  parameter int unsigned WIDTH = 5,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic     sys_clk,
  input  wire logic     sys_rst,
  fetcp_stream_if.snk   wr,
  fetcp_stream_if.src   rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_d;
    end
  end

  // Ready is a flop so the MAC sees back-pressure straight from a register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr.ready <= 1'b0;
    end else begin
      wr.ready <= (cnt_d < (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* fetcp_mac_model.sv */
`default_nettype none
module fetcp_mac_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       mac_ready,
  output logic            mac_valid,
  output logic            mac_tx_en,
  output logic [3:0]      mac_nibble,
  output logic            saw_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]  ent_q [$];
  int unsigned gap_q [$];
  int unsigned wait_n;
  initial begin
    mac_valid = 1'b0;
    mac_tx_en = 1'b0;
    mac_nibble = 4'h0;
    saw_full = 1'b0;
    wait_n = 0;
  end
  // Queue an entry; g idle cycles follow it
  task automatic push(input logic en, input logic [3:0] nib, input int unsigned g);
    ent_q.push_back({en, nib});
    gap_q.push_back(g);
  endtask
  // An entry stands until taken; released data lines wander
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      mac_valid <= 1'b0;
    end else begin
      if (mac_valid && !mac_ready) saw_full <= 1'b1;
      if (!mac_valid || mac_ready) begin
        if (wait_n > 0 || ent_q.size() == 0) begin
          if (wait_n > 0) wait_n--;
          mac_valid <= 1'b0;
          mac_nibble <= ~mac_nibble;
        end else begin
          {mac_tx_en, mac_nibble} <= ent_q.pop_front();
          wait_n = gap_q.pop_front();
          mac_valid <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* fetcp_pkg.sv */
// Overview of operation
// - Each data nibble becomes its 5-bit code-group
// - First two preamble nibbles become J then K
// - TX enable drop appends T then R
// - IDLE code-groups fill the gap between frames
// - HALT stays a distinct error code-group
// - Scrambler is an 11-bit closed-loop LFSR
// - Serial bit XORed with LFSR output
// - Scrambler seed derived from address straps
// - Bypass passes encoded stream unscrambled
// - NRZI encoding follows serialisation and scrambling
// - MLT-3 split into two alternating binary streams
// - Only MLT-3 output, no binary line mode
// - Nibbles become a 125 Mb/s serial stream
// - Sequencing follows the standard transmit state machine
`default_nettype none
package fetcp_pkg;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned LINE_MBPS    = 125;
  localparam int unsigned BIT_DIV      = CLK_MHZ / LINE_MBPS;
  localparam int unsigned CG_BITS      = 5;
  localparam int unsigned NIB_BITS     = 4;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam int unsigned FIFO_WIDTH   = NIB_BITS + 1;
  localparam int unsigned LFSR_BITS    = 11;
  localparam int unsigned LFSR_TAP_HI  = 10;
  localparam int unsigned LFSR_TAP_LO  = 8;
  localparam int unsigned SEED_WAIT    = 3;
  localparam logic [10:0] LFSR_RESET   = 11'h7ff;
  localparam logic [4:0]  CG_IDLE      = 5'h1f;
  localparam logic [4:0]  CG_J         = 5'h18;
  localparam logic [4:0]  CG_K         = 5'h11;
  localparam logic [4:0]  CG_T         = 5'h0d;
  localparam logic [4:0]  CG_R         = 5'h07;
  localparam logic [4:0]  CG_HALT      = 5'h04;

  typedef enum logic [2:0] {
    FETCP_ST_IDLE,
    FETCP_ST_J,
    FETCP_ST_DATA,
    FETCP_ST_T
  } fetcp_state_t;

  function automatic logic [4:0] fetcp_enc(input logic [3:0] nib);
    logic [4:0] cg;
    cg = CG_HALT;
    case (nib)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      4'hf: cg = 5'h1d;
      default: cg = CG_HALT;
    endcase
    return cg;
  endfunction
endpackage
`default_nettype wire

/* fetcp_stream_if.sv */
`default_nettype none
interface fetcp_stream_if #(
  parameter int unsigned W = 5
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* fetcp_tx.sv */
`default_nettype none
module fetcp_tx (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       mac_valid,
  input  wire logic       mac_tx_en,
  input  wire logic [3:0] mac_nibble,
  output logic            mac_ready,
  input  wire logic [4:0] phy_address_straps,
  input  wire logic       scramble_bypass,
  output logic            mlt_pos,
  output logic            mlt_neg
);
  fetcp_stream_if #(.W(fetcp_pkg::FIFO_WIDTH)) in_s ();
  fetcp_stream_if #(.W(fetcp_pkg::FIFO_WIDTH)) out_s ();

  assign in_s.valid = mac_valid;
  assign in_s.data  = {mac_tx_en, mac_nibble};
  assign mac_ready  = in_s.ready;

  fetcp_fifo #(
    .WIDTH (fetcp_pkg::FIFO_WIDTH),
    .DEPTH (fetcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wr      (in_s.snk),
    .rd      (out_s.src)
  );

  // Pin synchronisers: bypass and straps, three flops, change taken when stages 2 and 3 agree
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  logic [5:0] pin_q;

  // Stages run through reset so the straps have settled before the seed load
  always_ff @(posedge sys_clk) begin
    pin_s1_q <= {scramble_bypass, phy_address_straps};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_q <= '0;
    end else begin
      pin_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  logic       bypass;
  logic [4:0] straps;
  assign bypass = pin_q[5];
  assign straps = pin_q[4:0];

  // Bit enable at the line rate
  logic [1:0] div_q;
  logic       bit_en;
  assign bit_en = (div_q == 2'(fetcp_pkg::BIT_DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= bit_en ? '0 : div_q + 1'b1;
    end
  end

  logic [2:0] bit_cnt_q;
  logic       sym_en;
  assign sym_en = bit_en && (bit_cnt_q == 3'(fetcp_pkg::CG_BITS - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_cnt_q <= '0;
    end else if (bit_en) begin
      bit_cnt_q <= sym_en ? '0 : bit_cnt_q + 1'b1;
    end
  end

  // Code-group sequencer, one decision per code-group boundary
  fetcp_pkg::fetcp_state_t st_q;
  fetcp_pkg::fetcp_state_t st_d;
  logic [4:0] cg_q;
  logic [4:0] cg_d;
  logic       pop;
  logic       f_en;
  logic [3:0] f_nib;

  assign f_en         = out_s.data[4];
  assign f_nib        = out_s.data[3:0];
  assign out_s.ready  = pop;

  always_comb begin
    st_d = st_q;
    cg_d = cg_q;
    pop  = 1'b0;
    if (sym_en) begin
      case (st_q)
        fetcp_pkg::FETCP_ST_IDLE: begin
          if (out_s.valid && f_en) begin
            pop  = 1'b1;
            cg_d = fetcp_pkg::CG_J;
            st_d = fetcp_pkg::FETCP_ST_J;
          end else begin
            pop  = out_s.valid;
            cg_d = fetcp_pkg::CG_IDLE;
          end
        end
        fetcp_pkg::FETCP_ST_J: begin
          pop  = out_s.valid && f_en;
          cg_d = fetcp_pkg::CG_K;
          st_d = fetcp_pkg::FETCP_ST_DATA;
        end
        fetcp_pkg::FETCP_ST_DATA: begin
          if (!out_s.valid) begin
            cg_d = fetcp_pkg::CG_HALT;
          end else if (f_en) begin
            pop  = 1'b1;
            cg_d = fetcp_pkg::fetcp_enc(f_nib);
          end else begin
            pop  = 1'b1;
            cg_d = fetcp_pkg::CG_T;
            st_d = fetcp_pkg::FETCP_ST_T;
          end
        end
        fetcp_pkg::FETCP_ST_T: begin
          cg_d = fetcp_pkg::CG_R;
          st_d = fetcp_pkg::FETCP_ST_IDLE;
        end
        default: begin
          cg_d = fetcp_pkg::CG_IDLE;
          st_d = fetcp_pkg::FETCP_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= fetcp_pkg::FETCP_ST_IDLE;
      cg_q <= fetcp_pkg::CG_IDLE;
    end else begin
      st_q <= st_d;
      cg_q <= cg_d;
    end
  end

  // Serialiser, first code-group bit first
  logic [4:0] sh_q;
  logic       nrz_bit;
  assign nrz_bit = sh_q[4];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sh_q <= fetcp_pkg::CG_IDLE;
    end else if (sym_en) begin
      sh_q <= cg_d;
    end else if (bit_en) begin
      sh_q <= {sh_q[3:0], 1'b0};
    end
  end

  // Scrambler, seeded once the straps have settled after reset
  logic [10:0] lfsr_q;
  logic [1:0]  seed_cnt_q;
  logic        lfsr_out;
  logic        scr_bit;
  assign lfsr_out = lfsr_q[fetcp_pkg::LFSR_TAP_HI] ^ lfsr_q[fetcp_pkg::LFSR_TAP_LO];
  assign scr_bit  = bypass ? nrz_bit : (nrz_bit ^ lfsr_out);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seed_cnt_q <= 2'(fetcp_pkg::SEED_WAIT);
    end else if (seed_cnt_q != '0) begin
      seed_cnt_q <= seed_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lfsr_q <= fetcp_pkg::LFSR_RESET;
    end else if (seed_cnt_q == 2'h1) begin
      lfsr_q <= {straps, ~straps, 1'b1};
    end else if (bit_en) begin
      lfsr_q <= {lfsr_q[9:0], lfsr_out};
    end
  end

  // NRZI and MLT-3; only the three-level drive pair leaves the block
  logic       nrzi_q;
  logic       nrzi_prev_q;
  logic       nrzi_edge;
  logic [1:0] phase_q;
  assign nrzi_edge = (nrzi_q != nrzi_prev_q);

  // Previous NRZI level, for the MLT-3 step on each transition
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nrzi_prev_q <= 1'b0;
    end else begin
      nrzi_prev_q <= nrzi_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nrzi_q <= 1'b0;
    end else if (bit_en && scr_bit) begin
      nrzi_q <= ~nrzi_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_q <= '0;
    end else if (nrzi_edge) begin
      phase_q <= phase_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mlt_pos <= 1'b0;
      mlt_neg <= 1'b0;
    end else begin
      mlt_pos <= (phase_q == 2'h1);
      mlt_neg <= (phase_q == 2'h3);
    end
  end

  // Checks
  sequence seq_t_loaded;
    sym_en && st_q == fetcp_pkg::FETCP_ST_DATA && out_s.valid && !f_en;
  endsequence

  sequence seq_tr_out;
    cg_q == fetcp_pkg::CG_T ##10 cg_q == fetcp_pkg::CG_R;
  endsequence

  chk_data_encode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sym_en && st_q == fetcp_pkg::FETCP_ST_DATA && out_s.valid && f_en)
      |=> cg_q == fetcp_pkg::fetcp_enc($past(f_nib)))
    else $error("data code-group mismatch");
  chk_jk_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sym_en && st_q == fetcp_pkg::FETCP_ST_IDLE && out_s.valid && f_en)
      |=> cg_q == fetcp_pkg::CG_J ##10 cg_q == fetcp_pkg::CG_K)
    else $error("start delimiter not J then K");
  chk_tr_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seq_t_loaded |=> seq_tr_out)
    else $error("end delimiter not T then R");
  chk_idle_fill: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sym_en && st_q == fetcp_pkg::FETCP_ST_IDLE && !(out_s.valid && f_en))
      |=> cg_q == fetcp_pkg::CG_IDLE)
    else $error("idle gap not filled");
  chk_underrun_halt: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sym_en && st_q == fetcp_pkg::FETCP_ST_DATA && !out_s.valid) |=> cg_q == fetcp_pkg::CG_HALT)
    else $error("underrun did not send halt");
  chk_lfsr_shift: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (bit_en && seed_cnt_q == '0) |=> lfsr_q == {$past(lfsr_q[9:0]), $past(lfsr_out)})
    else $error("scrambler did not advance");
  chk_scramble_mix: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bypass |-> scr_bit == (sh_q[4] ^ lfsr_q[10] ^ lfsr_q[8]))
    else $error("scrambled bit wrong");
  chk_seed_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    seed_cnt_q == 2'h1 |=> lfsr_q[10:6] == $past(straps))
    else $error("seed not taken from straps");
  chk_bypass_path: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bypass |-> scr_bit == sh_q[4])
    else $error("bypass still scrambles");
  chk_nrzi_rule: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bit_en |=> (nrzi_q != $past(nrzi_q)) == $past(scr_bit))
    else $error("nrzi level wrong");
  chk_mlt_pair: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(mlt_pos && mlt_neg))
    else $error("mlt3 drive pair overlap");
  chk_mlt_phase: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(mlt_pos) |-> $past(phase_q) == 2'h1)
    else $error("mlt3 plus drive out of phase");
  chk_mlt_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nrzi_edge |=> phase_q == $past(phase_q) + 2'h1)
    else $error("mlt3 phase did not step on nrzi transition");
  chk_bit_rate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bit_en |=> !bit_en ##1 bit_en)
    else $error("line bit rate wrong");
endmodule
`default_nettype wire

/* testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk;
  logic       sys_rst;
  logic       mac_valid;
  logic       mac_tx_en;
  logic [3:0] mac_nibble;
  logic       mac_ready;
  logic       scramble_bypass;
  logic       mlt_pos;
  logic       mlt_neg;
  logic       saw_full;
  logic       bits_q [$];
  logic [1:0] lvl_q;
  logic       neg_last_q;
  logic       armed_q;
  int         gap_c;
  int         n_errors;
  int         cmp_count;
  int         cycles;
  localparam logic [4:0] CG_TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                         5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  fetcp_tx u_fetcp_tx (.sys_clk(sys_clk), .sys_rst(sys_rst), .mac_valid(mac_valid), .mac_tx_en(mac_tx_en),
    .mac_nibble(mac_nibble), .mac_ready(mac_ready), .phy_address_straps(5'h13),
    .scramble_bypass(scramble_bypass), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg));
  fetcp_mac_model u_fetcp_mac_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .mac_ready(mac_ready),
    .mac_valid(mac_valid), .mac_tx_en(mac_tx_en), .mac_nibble(mac_nibble), .saw_full(saw_full));
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      summarize();
    end
  end
  // Line decoder: each level change is a one, spacing gives the zeros
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
      lvl_q <= 2'b00;
      gap_c <= 0;
    end else begin
      check("both drives on", mlt_pos & mlt_neg, 1'b0);
      gap_c <= gap_c + 1;
      if ({mlt_pos, mlt_neg} != lvl_q) begin
        gap_c <= 1;
        lvl_q <= {mlt_pos, mlt_neg};
        armed_q <= 1'b1;
        if (lvl_q != 2'b00) check("return to zero", {mlt_pos, mlt_neg}, 2'b00);
        else if (armed_q) check("level order", mlt_pos, neg_last_q);
        if (mlt_neg) neg_last_q <= 1'b1;
        if (mlt_pos) neg_last_q <= 1'b0;
        if (armed_q) begin
          check("bit spacing", gap_c[0], 1'b0);
          for (int i = 2; i < gap_c; i += 2) bits_q.push_back(1'b0);
          bits_q.push_back(1'b1);
        end
      end
    end
  end
  task automatic get_group(output logic [4:0] g);
    int t;
    t = 0;
    while (bits_q.size() < 5 && t < 500) begin
      @(posedge sys_clk);
      t++;
    end
    g = 5'h00;
    for (int b = 0; b < 5; b++) g = {g[3:0], (bits_q.size() > 0) ? bits_q.pop_front() : 1'b0};
  endtask
  task automatic find_jk;
    logic [9:0] w;
    int t;
    w = 10'h000;
    t = 0;
    while (w != {fetcp_pkg::CG_J, fetcp_pkg::CG_K} && t < 3000) begin
      if (bits_q.size() > 0) w = {w[8:0], bits_q.pop_front()};
      else @(posedge sys_clk);
      t++;
    end
    check("start delimiter", w, {fetcp_pkg::CG_J, fetcp_pkg::CG_K});
  endtask
  task automatic end_check;
    logic [4:0] g;
    get_group(g); check("end group T", g, fetcp_pkg::CG_T);
    get_group(g); check("end group R", g, fetcp_pkg::CG_R);
    for (int n = 0; n < 3; n++) begin get_group(g); check("idle", g, fetcp_pkg::CG_IDLE); end
  endtask
  task automatic t_scrambled_idle;
    logic [63:0] k;
    int m1;
    int m2;
    bits_q.delete();
    for (int i = 0; i < 64; i++) begin
      while (bits_q.size() == 0) @(posedge sys_clk);
      k[i] = ~bits_q.pop_front();
    end
    m1 = 0;
    m2 = 0;
    for (int i = 11; i < 64; i++) begin
      m1 += int'(k[i] ^ k[i-11] ^ k[i-9]);
      m2 += int'(k[i] ^ k[i-11] ^ k[i-2]);
    end
    check("scrambler recurrence", (m1 == 0) || (m2 == 0), 1'b1);
    check("scrambler running", k != 64'h0, 1'b1);
  endtask
  task automatic t_frame;
    logic [4:0] g;
    bits_q.delete();
    u_fetcp_mac_model.push(1'b1, 4'h5, 0);
    u_fetcp_mac_model.push(1'b1, 4'h5, 0);
    for (int n = 0; n < 16; n++) u_fetcp_mac_model.push(1'b1, 4'(n), 0);
    u_fetcp_mac_model.push(1'b0, 4'h0, 0);
    find_jk();
    for (int n = 0; n < 16; n++) begin get_group(g); check("data group", g, CG_TAB[n]); end
    end_check();
    check("fifo back-pressure", saw_full, 1'b1);
  endtask
  task automatic t_underrun;
    logic [4:0] g;
    int nh;
    bits_q.delete();
    u_fetcp_mac_model.push(1'b1, 4'h5, 0);
    u_fetcp_mac_model.push(1'b1, 4'h5, 0);
    u_fetcp_mac_model.push(1'b1, 4'h3, 40);
    u_fetcp_mac_model.push(1'b1, 4'h9, 0);
    u_fetcp_mac_model.push(1'b0, 4'h0, 0);
    find_jk();
    get_group(g); check("group before gap", g, CG_TAB[3]);
    nh = 0;
    get_group(g);
    while (g === fetcp_pkg::CG_HALT && nh < 20) begin
      nh++;
      get_group(g);
    end
    check("halt during underrun", nh > 0, 1'b1);
    check("group after gap", g, CG_TAB[9]);
    end_check();
  endtask
  initial begin
    sys_rst = 1'b1;
    scramble_bypass = 1'b0;
    neg_last_q = 1'b0;
    cycles = 0;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (50) @(posedge sys_clk);
    t_scrambled_idle();
    scramble_bypass <= 1'b1;
    repeat (40) @(posedge sys_clk);
    t_frame();
    t_underrun();
    summarize();
  end
endmodule
`default_nettype wire
